// *** rtl/scfd_pkg.sv ***
// scfd_pkg: constants, types and the lock decode shared by the configuration fuse decoder.
// assumes a single 10 MHz core clock; the fuse cell itself lives outside and is read as a byte.
package scfd_pkg;

  // ---------------------------------------------------------------
  // field positions of the configuration/security byte
  // ---------------------------------------------------------------
  localparam int unsigned BIT_DSPEED  = 7;  // double_speed_select
  localparam int unsigned BIT_BOOT    = 6;  // boot_jump_select
  localparam int unsigned OSC_HI      = 5;  // osc_range_select msb
  localparam int unsigned OSC_LO      = 4;  // osc_range_select lsb
  localparam int unsigned LOCK_HI     = 2;  // lock_bit_two
  localparam int unsigned LOCK_LO     = 0;  // lock_bit_zero

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [7:0]  CFG_DELIVERED = 8'hb8;    // standard mode, bootloader, 32 MHz, level 4
  localparam logic [7:0]  CFG_ERASED    = 8'hff;    // inactive, unlocked
  localparam logic [15:0] BOOT_APP      = 16'h0000;
  localparam logic [15:0] BOOT_LOADER   = 16'hf400;
  localparam logic [3:0]  CLK_PER_FAST  = 4'h6;     // clocks per instruction, fast mode
  localparam logic [3:0]  CLK_PER_STD   = 4'hc;     // clocks per instruction, standard mode
  localparam int unsigned CLK_HZ        = 10000000;

  // oscillator range codes, descending range
  localparam logic [1:0] OSC_32MHZ = 2'h3;
  localparam logic [1:0] OSC_16MHZ = 2'h2;
  localparam logic [1:0] OSC_8MHZ  = 2'h1;
  localparam logic [1:0] OSC_BAD   = 2'h0;

  // security levels
  localparam logic [2:0] LVL_1 = 3'h1;
  localparam logic [2:0] LVL_2 = 3'h2;
  localparam logic [2:0] LVL_3 = 3'h3;
  localparam logic [2:0] LVL_4 = 3'h4;

  // parallel programmer commands, taken from the command pins
  typedef enum logic [2:0] {
    SCFD_CMD_NONE,
    SCFD_CMD_READ_CFG,
    SCFD_CMD_WRITE_CFG,
    SCFD_CMD_CHIP_ERASE,
    SCFD_CMD_READ_ID,
    SCFD_CMD_WRITE_FLASH,
    SCFD_CMD_WRITE_EEPROM,
    SCFD_CMD_READ_FLASH
  } scfd_cmd_t;

  // lock bits are programmed at zero; the highest programmed bit wins
  function automatic logic [2:0] scfd_lock_level(input logic [2:0] lb);
    logic [2:0] lvl;
    lvl = LVL_1;
    if (!lb[2]) begin
      lvl = LVL_4;
    end else if (!lb[1]) begin
      lvl = LVL_3;
    end else if (!lb[0]) begin
      lvl = LVL_2;
    end
    return lvl;
  endfunction

endpackage

// *** rtl/scfd_sync2.sv ***
// scfd_sync2: two-stage synchroniser for a bundle of pin levels.
// assumes multi-bit bundles are held stable by the sender around the strobe that qualifies them.
`timescale 1ns/100ps
module scfd_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } scfd_sync_t;

  scfd_sync_t s_reg;
  scfd_sync_t s_next;

  // ---------------------------------------------------------------
  // stages; the first stage feeds only the second
  // ---------------------------------------------------------------
  always_comb begin
    s_next        = s_reg;
    s_next.meta   = d;
    s_next.stable = s_reg.meta;
  end

  // the stages stay out of reset: the core latches the pin level on the first edge after
  // release, so the stages must hold the settled pin by then and not a cleared zero
  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign q = s_reg.stable;

endmodule

// *** rtl/scfd_core.sv ***
// scfd_core: decoder and guard for the nonvolatile configuration and security byte.
// assumes the fuse byte is read combinationally on the core clock and that the parallel
// programmer pins are asynchronous and held stable while their strobe is high.
`timescale 1ns/100ps
module scfd_core
  import scfd_pkg::*;
#(
  parameter logic [7:0] ID_MAKER  = 8'h5a,  // arbitrary value
  parameter logic [7:0] ID_FAMILY = 8'h3c,  // arbitrary value
  parameter logic [7:0] ID_MEMORY = 8'h21,  // arbitrary value
  parameter logic [7:0] ID_NAME   = 8'h07   // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        srst,
  // fuse cell
  input  wire logic [7:0]  nv_byte,
  output      logic        nv_wr,
  output      logic [7:0]  nv_wdata,
  // parallel programmer pins (asynchronous)
  input  wire logic        prog_mode,
  input  wire logic        prog_strobe,
  input  wire logic [2:0]  prog_cmd,
  input  wire logic [1:0]  prog_addr,
  input  wire logic [7:0]  prog_wdata,
  output      logic [7:0]  prog_rdata,
  output      logic        prog_ack,
  output      logic        prog_refused,
  // flash and eeprom engines
  input  wire logic [7:0]  flash_rdata,
  output      logic        flash_wr_req,
  output      logic        eeprom_wr_req,
  output      logic        flash_erase_req,
  // core and pins
  input  wire logic        external_access_pin,
  input  wire logic        ssb_isp_block,
  input  wire logic        xaf_req_fw,
  input  wire logic        xaf_req_core,
  output      logic        xaf_grant,
  output      logic        isp_code_access,
  output      logic        double_speed_mode,
  output      logic [3:0]  clocks_per_instr,
  output      logic [15:0] boot_addr,
  output      logic [1:0]  osc_range_select,
  output      logic [2:0]  security_level,
  output      logic        code_read_block,
  output      logic        par_prog_block,
  output      logic        par_verify_block,
  output      logic        ext_exec_block,
  output      logic        ext_access_eff,
  output      logic        cfg_loaded
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        loaded;
    logic        strobe_d;
    logic [7:0]  cfg;
    logic        ea_latched;
    logic        ea_eff;
    logic [2:0]  level;
    logic        blk_code;
    logic        blk_prog;
    logic        blk_verify;
    logic        blk_exec;
    logic        isp_ok;
    logic        xaf_ok;
    logic [7:0]  rdata;
    logic        ack;
    logic        refused;
    logic        nv_wr;
    logic [7:0]  nv_wdata;
    logic        fl_wr;
    logic        ee_wr;
    logic        erase;
  } scfd_state_t;

  scfd_state_t r_reg;
  scfd_state_t r_next;

  logic [15:0] sy;
  logic        sy_ea;
  logic        sy_en;
  logic        sy_strobe;
  scfd_cmd_t   sy_cmd;
  logic [1:0]  sy_addr;
  logic [7:0]  sy_wdata;
  logic        take;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  scfd_sync2 #(.W(16)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({external_access_pin, prog_mode, prog_strobe, prog_cmd, prog_addr, prog_wdata}),
    .q    (sy)
  );

  assign sy_ea     = sy[15];
  assign sy_en     = sy[14];
  assign sy_strobe = sy[13];
  assign sy_cmd    = scfd_cmd_t'(sy[12:10]);
  assign sy_addr   = sy[9:8];
  assign sy_wdata  = sy[7:0];

  // one request per rising strobe, only in programming mode and once the byte is known
  assign take = sy_strobe & ~r_reg.strobe_d & sy_en & r_reg.loaded;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    r_next          = r_reg;
    r_next.strobe_d = sy_strobe;
    r_next.ack      = 1'b0;
    r_next.refused  = 1'b0;
    r_next.nv_wr    = 1'b0;
    r_next.fl_wr    = 1'b0;
    r_next.ee_wr    = 1'b0;
    r_next.erase    = 1'b0;

    // sample once after reset release; later fuse writes wait for the next reset
    if (!r_reg.loaded) begin
      r_next.loaded     = 1'b1;
      r_next.cfg        = nv_byte;
      r_next.ea_latched = sy_ea;
      r_next.level      = scfd_lock_level(nv_byte[LOCK_HI:LOCK_LO]);
    end

    // protection levels nest: each level keeps the blocks of the one below
    r_next.blk_code   = r_next.level >= LVL_2;
    r_next.blk_prog   = r_next.level >= LVL_2;
    r_next.blk_verify = r_next.level >= LVL_3;
    r_next.blk_exec   = r_next.level == LVL_4;
    // from level 2 the access pin is the value caught after reset
    r_next.ea_eff     = (r_next.level >= LVL_2) ? r_reg.ea_latched : sy_ea;
    // in-system access ignores the lock level; the software security bits decide
    r_next.isp_ok     = ~ssb_isp_block;
    // program-space fetches reach the extra page only while xaf_req_fw is also high
    r_next.xaf_ok     = xaf_req_fw | (sy_en & ~xaf_req_core);

    // programmer commands; the byte has no other access path
    if (take) begin
      r_next.ack = 1'b1;
      case (sy_cmd)
        SCFD_CMD_READ_CFG: begin
          r_next.rdata = nv_byte;
        end
        SCFD_CMD_WRITE_CFG: begin
          if (sy_wdata[OSC_HI:OSC_LO] == OSC_BAD) begin
            r_next.ack     = 1'b0;  // forbidden oscillator code never reaches the fuse
            r_next.refused = 1'b1;
          end else begin
            r_next.nv_wr    = 1'b1;
            // lock bits only program downward, so only an erase can unlock
            r_next.nv_wdata = {sy_wdata[7:3], sy_wdata[LOCK_HI:LOCK_LO] & nv_byte[LOCK_HI:LOCK_LO]};
          end
        end
        SCFD_CMD_CHIP_ERASE: begin
          r_next.erase    = 1'b1;
          r_next.nv_wr    = 1'b1;
          r_next.nv_wdata = CFG_ERASED;
        end
        SCFD_CMD_READ_ID: begin
          // reference bytes are open at every level
          case (sy_addr)
            2'h0:    r_next.rdata = ID_MAKER;
            2'h1:    r_next.rdata = ID_FAMILY;
            2'h2:    r_next.rdata = ID_MEMORY;
            default: r_next.rdata = ID_NAME;
          endcase
        end
        SCFD_CMD_WRITE_FLASH, SCFD_CMD_WRITE_EEPROM: begin
          if (r_reg.blk_prog) begin
            r_next.ack     = 1'b0;
            r_next.refused = 1'b1;
          end else begin
            r_next.fl_wr = sy_cmd == SCFD_CMD_WRITE_FLASH;
            r_next.ee_wr = sy_cmd == SCFD_CMD_WRITE_EEPROM;
          end
        end
        SCFD_CMD_READ_FLASH: begin
          if (r_reg.blk_verify) begin
            r_next.ack     = 1'b0;
            r_next.refused = 1'b1;
            r_next.rdata   = 8'hff;
          end else begin
            r_next.rdata = flash_rdata;
          end
        end
        default: begin
          r_next.ack     = 1'b0;
          r_next.refused = 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers; until sampled the settings match the delivered byte
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      r_reg            <= '0;
      r_reg.cfg        <= CFG_DELIVERED;
      r_reg.level      <= LVL_4;
      r_reg.blk_code   <= 1'b1;
      r_reg.blk_prog   <= 1'b1;
      r_reg.blk_verify <= 1'b1;
      r_reg.blk_exec   <= 1'b1;
      r_reg.rdata      <= 8'hff;
      r_reg.nv_wdata   <= CFG_ERASED;
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign nv_wr             = r_reg.nv_wr;
  assign nv_wdata          = r_reg.nv_wdata;
  assign prog_rdata        = r_reg.rdata;
  assign prog_ack          = r_reg.ack;
  assign prog_refused      = r_reg.refused;
  assign flash_wr_req      = r_reg.fl_wr;
  assign eeprom_wr_req     = r_reg.ee_wr;
  assign flash_erase_req   = r_reg.erase;
  assign xaf_grant         = r_reg.xaf_ok;
  assign isp_code_access   = r_reg.isp_ok;
  // speed bit at zero means the fast six-clock mode
  assign double_speed_mode = ~r_reg.cfg[BIT_DSPEED];
  assign clocks_per_instr  = r_reg.cfg[BIT_DSPEED] ? CLK_PER_STD : CLK_PER_FAST;
  assign boot_addr         = r_reg.cfg[BIT_BOOT] ? BOOT_APP : BOOT_LOADER;
  // a forbidden code in the fuse is run at the widest range rather than an unknown one
  assign osc_range_select  = (r_reg.cfg[OSC_HI:OSC_LO] == OSC_BAD) ? OSC_32MHZ : r_reg.cfg[OSC_HI:OSC_LO];
  assign security_level    = r_reg.level;
  assign code_read_block   = r_reg.blk_code;
  assign par_prog_block    = r_reg.blk_prog;
  assign par_verify_block  = r_reg.blk_verify;
  assign ext_exec_block    = r_reg.blk_exec;
  assign ext_access_eff    = r_reg.ea_eff;
  assign cfg_loaded        = r_reg.loaded;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_fast_mode_clk:
    assert property (r_reg.loaded |-> (clocks_per_instr == 4'h6) == (r_reg.cfg[7] == 1'b0))
      else $error("clocks per instruction disagree with speed bit");
  a_boot_vector:
    assert property (r_reg.loaded |-> boot_addr == (r_reg.cfg[6] ? 16'h0000 : 16'hf400))
      else $error("boot address disagrees with boot bit");
  a_osc_bad_refused:
    assert property (take && sy_cmd == SCFD_CMD_WRITE_CFG && sy_wdata[5:4] == 2'h0 |=> prog_refused && !nv_wr)
      else $error("forbidden oscillator code was written");
  a_level_one_free:
    assert property (security_level == 3'h1 |-> !(code_read_block || par_prog_block || ext_exec_block))
      else $error("level one carries a restriction");
  a_prog_blocked:
    assert property (take && sy_cmd == SCFD_CMD_WRITE_FLASH && security_level >= 3'h2
                     |=> prog_refused && !flash_wr_req)
      else $error("parallel write passed a lock");
  a_verify_blocked:
    assert property (take && sy_cmd == SCFD_CMD_READ_FLASH && security_level >= 3'h3 |=> prog_refused ##1 !prog_ack)
      else $error("parallel verify passed a lock");
  a_exec_level_four:
    assert property ($rose(r_reg.loaded) |-> ext_exec_block == !$past(nv_byte[2]))
      else $error("external execution block disagrees with lock bit two");
  a_erase_unlock:
    assert property (take && sy_cmd == SCFD_CMD_CHIP_ERASE |=> flash_erase_req && nv_wr && nv_wdata == 8'hff)
      else $error("chip erase did not restore the unlocked byte");
  a_id_open:
    assert property (take && sy_cmd == SCFD_CMD_READ_ID |=> prog_ack && !prog_refused)
      else $error("part reference read refused");
  a_hold_stable:
    assert property (r_reg.loaded ##1 r_reg.loaded |-> $stable(boot_addr) && $stable(security_level))
      else $error("decoded settings moved before reset");

endmodule

// *** sim/scfd_fuse_model.sv ***
// scfd_fuse_model: behavioural fuse cell holding the configuration/security byte.
// assumes one clock shared with the decoder; the cell keeps its value across srst.
`timescale 1ns/100ps
module scfd_fuse_model #(
  parameter logic [7:0] INIT = 8'hb8
) (
  input  wire logic       clk,
  input  wire logic       nv_wr,
  input  wire logic [7:0] nv_wdata,
  output      logic [7:0] nv_byte
);
  // ---------------------------------------------------------------
  // cell contents
  // ---------------------------------------------------------------
  // nonvolatile: no reset term, so the byte survives every srst
  logic [7:0] cell_reg = INIT;
  // only the programmer port's write pulse reaches the cell
  always @(posedge clk) begin
    if (nv_wr) begin
      cell_reg <= nv_wdata;
    end
  end
  assign nv_byte = cell_reg;
endmodule

// *** sim/testbench.sv ***
// testbench: drives the parallel programmer pins of scfd_core and checks the decode.
// assumes the fuse model of sim/ and a single 10 MHz clock.
`timescale 1ns/100ps
module testbench;
  import scfd_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [7:0] IDS [4] = '{8'h11, 8'h22, 8'h33, 8'h44}; // arbitrary values
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        prog_mode = 1'b1;
  logic        prog_strobe = 1'b0;
  logic [2:0]  prog_cmd = 3'h0;
  logic [1:0]  prog_addr = 2'h0;
  logic [7:0]  prog_wdata = 8'h00;
  logic [7:0]  flash_rdata = 8'h3a;
  logic        external_access_pin = 1'b1;
  logic        ssb_isp_block = 1'b0;
  logic        xaf_req_fw = 1'b0;
  logic        xaf_req_core = 1'b0;
  logic [7:0]  nv_byte, nv_wdata, prog_rdata;
  logic        nv_wr, prog_ack, prog_refused, flash_wr_req, eeprom_wr_req, flash_erase_req;
  logic        xaf_grant, isp_code_access, double_speed_mode, code_read_block, par_prog_block;
  logic        par_verify_block, ext_exec_block, ext_access_eff, cfg_loaded;
  logic [3:0]  clocks_per_instr;
  logic [15:0] boot_addr;
  logic [1:0]  osc_range_select;
  logic [2:0]  security_level;
  logic [5:0]  ev;
  int          failures = 0;
  int          num_checks = 0;

  always #50 clk = ~clk;

  scfd_fuse_model #(.INIT(8'hb8)) i_scfd_fuse_model (
    .clk(clk), .nv_wr(nv_wr), .nv_wdata(nv_wdata), .nv_byte(nv_byte));

  scfd_core #(.ID_MAKER(IDS[0]), .ID_FAMILY(IDS[1]), .ID_MEMORY(IDS[2]), .ID_NAME(IDS[3])) i_scfd_core (
    .clk(clk), .srst(srst), .nv_byte(nv_byte), .nv_wr(nv_wr), .nv_wdata(nv_wdata),
    .prog_mode(prog_mode), .prog_strobe(prog_strobe), .prog_cmd(prog_cmd), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .prog_ack(prog_ack), .prog_refused(prog_refused),
    .flash_rdata(flash_rdata), .flash_wr_req(flash_wr_req), .eeprom_wr_req(eeprom_wr_req),
    .flash_erase_req(flash_erase_req), .external_access_pin(external_access_pin),
    .ssb_isp_block(ssb_isp_block), .xaf_req_fw(xaf_req_fw), .xaf_req_core(xaf_req_core),
    .xaf_grant(xaf_grant), .isp_code_access(isp_code_access), .double_speed_mode(double_speed_mode),
    .clocks_per_instr(clocks_per_instr), .boot_addr(boot_addr), .osc_range_select(osc_range_select),
    .security_level(security_level), .code_read_block(code_read_block), .par_prog_block(par_prog_block),
    .par_verify_block(par_verify_block), .ext_exec_block(ext_exec_block),
    .ext_access_eff(ext_access_eff), .cfg_loaded(cfg_loaded));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // waits n edges, then steps off the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // pins drive on a rising edge; reset held 4 edges so the pin synchronisers flush
  task automatic rst();
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    tick(2);
  endtask

  task automatic set_pins(input logic ea, input logic ssb, input logic fw, input logic core);
    @(posedge clk);
    external_access_pin <= ea;
    ssb_isp_block <= ssb;
    xaf_req_fw <= fw;
    xaf_req_core <= core;
    tick(4);
  endtask

  // one strobe: pins stable while high, high at least 4 clocks and low at least 5 clocks.
  // ev = {ack, refused, nv_wr, flash_wr, eeprom_wr, erase} seen in the answer cycle
  task automatic cmd(input scfd_cmd_t c, input logic [1:0] a, input logic [7:0] d);
    int n;
    ev = '0;
    @(posedge clk);
    prog_cmd <= c;
    prog_addr <= a;
    prog_wdata <= d;
    prog_strobe <= 1'b1;
    for (n = 0; n < 10 && ev == 6'h00; n++) begin
      tick(1);
      ev = {prog_ack, prog_refused, nv_wr, flash_wr_req, eeprom_wr_req, flash_erase_req};
    end
    @(posedge clk);
    prog_strobe <= 1'b0;
    tick(4);
  endtask

  task automatic chk_dec(input logic [15:0] boot, input logic [3:0] cpi, input logic [1:0] osc,
                         input logic [2:0] lvl, input logic [3:0] blk);
    chk(boot_addr, boot, "boot address");
    chk(16'(clocks_per_instr), 16'(cpi), "clocks per instruction");
    chk(16'(double_speed_mode), 16'(cpi == 4'h6), "speed mode");
    chk(16'(osc_range_select), 16'(osc), "oscillator range");
    chk(16'(security_level), 16'(lvl), "security level");
    chk(16'({code_read_block, par_prog_block, par_verify_block, ext_exec_block}), 16'(blk), "blocks");
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  // the run is a few hundred cycles; the watchdog allows over a hundred times that
  initial begin
    #4000000;
    failures++;
    end_of_test();
  end

  initial begin
    scfd_cmd_t shut [4];
    shut = '{SCFD_CMD_NONE, SCFD_CMD_WRITE_FLASH, SCFD_CMD_WRITE_EEPROM, SCFD_CMD_READ_FLASH};
    rst();
    chk(16'(cfg_loaded), 16'h1, "loaded");
    chk_dec(16'hf400, 4'hc, 2'h3, 3'h4, 4'hf);
    for (int i = 0; i < 4; i++) begin
      cmd(SCFD_CMD_READ_ID, 2'(i), 8'h00);
      chk(16'({ev, prog_rdata}), 16'({6'h20, IDS[i]}), "part reference");
      cmd(shut[i], 2'h0, 8'h00);
      chk(16'({ev, prog_rdata}), 16'({6'h10, (i == 3) ? 8'hff : IDS[i]}), "locked command");
    end
    cmd(SCFD_CMD_READ_CFG, 2'h0, 8'h00);
    chk(16'({ev, prog_rdata}), 16'h20b8, "read byte");
    cmd(SCFD_CMD_WRITE_CFG, 2'h0, 8'hcf);
    chk(16'({ev, nv_byte}), 16'h10b8, "bad oscillator code");
    set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    chk(16'(ext_access_eff), 16'h1, "access pin latched");
    cmd(SCFD_CMD_CHIP_ERASE, 2'h0, 8'h00);
    chk(16'({ev, nv_byte}), 16'h29ff, "chip erase");
    chk_dec(16'hf400, 4'hc, 2'h3, 3'h4, 4'hf);
    set_pins(1'b1, 1'b0, 1'b0, 1'b0);
    rst();
    chk_dec(16'h0000, 4'hc, 2'h3, 3'h1, 4'h0);
    cmd(SCFD_CMD_WRITE_FLASH, 2'h0, 8'h00);
    chk(16'(ev), 16'h24, "flash write open");
    cmd(SCFD_CMD_WRITE_EEPROM, 2'h0, 8'h00);
    chk(16'(ev), 16'h22, "eeprom write open");
    set_pins(1'b0, 1'b1, 1'b0, 1'b1);
    chk(16'({ext_access_eff, isp_code_access, xaf_grant}), 16'h0, "live pin, isp, xaf");
    set_pins(1'b1, 1'b0, 1'b1, 1'b1);
    chk(16'({ext_access_eff, isp_code_access, xaf_grant}), 16'h7, "live pin, isp, xaf");
    set_pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk(16'(xaf_grant), 16'h1, "programmer reaches page");
    // out of programming mode a strobe is ignored and the programmer loses the page
    @(posedge clk);
    prog_mode <= 1'b0;
    cmd(SCFD_CMD_READ_ID, 2'h0, 8'h00);
    chk(16'({ev, xaf_grant}), 16'h0, "strobe outside programming mode");
    @(posedge clk);
    prog_mode <= 1'b1;
    // the programmer verifies the flash before it sets level 2
    cmd(SCFD_CMD_READ_FLASH, 2'h0, 8'h00);
    chk(16'({ev, prog_rdata}), 16'h203a, "verify before locking");
    cmd(SCFD_CMD_WRITE_CFG, 2'h0, 8'h66);
    chk(16'({ev, nv_byte}), 16'h2866, "write byte");
    rst();
    chk_dec(16'h0000, 4'h6, 2'h2, 3'h2, 4'hc);
    set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    chk(16'(ext_access_eff), 16'h1, "access pin latched");
    cmd(SCFD_CMD_READ_FLASH, 2'h0, 8'h00);
    chk(16'({ev, prog_rdata}), 16'h203a, "verify open");
    cmd(SCFD_CMD_WRITE_FLASH, 2'h0, 8'h00);
    chk(16'(ev), 16'h10, "flash write shut");
    cmd(SCFD_CMD_WRITE_CFG, 2'h0, 8'h7d);
    chk(16'(nv_byte), 16'h7c, "lock bits only program");
    rst();
    chk_dec(16'h0000, 4'h6, 2'h3, 3'h3, 4'he);
    cmd(SCFD_CMD_READ_FLASH, 2'h0, 8'h00);
    chk(16'({ev, prog_rdata}), 16'h10ff, "verify shut");
    cmd(SCFD_CMD_CHIP_ERASE, 2'h0, 8'h00);
    cmd(SCFD_CMD_WRITE_CFG, 2'h0, 8'h5f);
    rst();
    chk_dec(16'h0000, 4'h6, 2'h1, 3'h1, 4'h0);
    end_of_test();
  end
endmodule
